// ===== src/cim_pkg.sv
// Purpose: Shared constants and types for the idle, acknowledge and MAC executor.
// Assumes: Instruction words arrive left aligned, first opcode word in bits 31:16.
// Notes: Product shift mode codes are local to this block.
package cim_pkg;
    // ******************************
    // Opcodes
    // ******************************
    localparam logic [15:0] OP_INTERRUPT_ACK_INSTR = 16'h763F;
    localparam logic [15:0] OP_IDLE = 16'h7621;
    localparam logic [15:0] OP_MACL = 16'h564D;
    localparam logic [15:0] OP_MPYAL = 16'h564C;
    localparam logic [7:0] MACL_NOINC = 8'hC7;
    localparam logic [7:0] MACL_POSTINC = 8'h87;
    localparam logic [7:0] MPYAL_SUB = 8'h00;
    localparam int IMM_W = 16;
    localparam int WORD_W = 32;
    localparam int PADDR_W = 22;
    localparam int TEMP_W = 38;
    localparam int IRQ_N = 16;
    localparam int SYNC_N = IRQ_N + 1;
    // ******************************
    // Product shift mode encodings
    // ******************************
    localparam logic [3:0] PM_L4 = 4'h0;
    localparam logic [3:0] PM_L1 = 4'h1;
    localparam logic [3:0] PM_ZERO = 4'h2;
    localparam logic [3:0] PM_R1 = 4'h3;
    localparam logic [3:0] PM_R2 = 4'h4;
    localparam logic [3:0] PM_R3 = 4'h5;
    localparam logic [3:0] PM_R4 = 4'h6;
    localparam logic [3:0] PM_R5 = 4'h7;
    localparam logic [3:0] PM_R6 = 4'h8;
    // ******************************
    // Reset values
    // ******************************
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [21:0] PC_RST = 22'h000000;
    localparam logic [7:0] RPT_RST = 8'h00;
    // ******************************
    // Types
    // ******************************
    typedef struct packed {
        logic z;
        logic n;
        logic c;
        logic v;
    } cim_flags_t;
    typedef struct packed {
        logic [31:0] acc;
        logic c;
        logic v;
    } cim_accres_t;
    typedef enum logic [2:0] {IDL_RUN, IDL_FLUSH, IDL_DRAIN, IDL_FILL, IDL_GATED,
        IDL_SLEEP} cim_idle_t;
    typedef enum logic [1:0] {MAC_OFF, MAC_FETCH, MAC_EXEC} cim_mac_t;
endpackage

// ===== src/cim_exec.sv
// Purpose: Executes interrupt acknowledge, idle, program-memory MAC and multiply-add-previous.
// Assumes: Program memory returns read data one cycle after PROG_RD_OUT is high.
// Notes: Runs on the free-running input clock; the core clock gate is an output.
// Contract
// - acknowledge drives its 16-bit immediate on data bus 15:0 for one cycle
// - non-repeatable instruction after repeat prefix clears repeat count, runs once
// - idle flushes pipeline, waits memory cycles done, then sets idle status flag
// - core clock gated once instruction buffer full; clock output keeps running
// - program counter holds idle instruction address while idle
// - idle output goes high after the core clock stops
// - enabled or nonmaskable interrupt clears flag, advances PC by one, exits idle
// - maskable wake needs its enable bit; global mask does not block wake
// - maskable wake with global mask zero runs service routine, else skips it
// - nonmaskable wake always runs the service routine
// - program MAC decoded from two encodings, takes N+2 cycles
// - program MAC first adds unsigned unshifted product into accumulator
// - second operand read via pointer seven from 22-bit program space, signed
// - keep product bits 37:0 and select stored bits by shift mode
// - post-increment encoding adds one to pointer seven after the read
// - operand field update of pointer seven beats the post-increment
// - zero flag on accumulator zero, negative flag from accumulator bit 31
// - carry from accumulate; overflow set on signed overflow, else kept
// - unsigned carry counter counts every accumulate carry, ignores saturate mode
// - repeated MAC runs N+1 times; overflow keeps any intermediate overflow
// - multiply-add-previous adds product then stores shifted multiplicand product
// - multiply-add-previous updates flags and counter like program MAC
`timescale 1ns/10ps
`default_nettype none
module cim_exec #(
    parameter int OVC_W = 16
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [31:0] INSTR_WORD_IN,
    input wire logic [21:0] INSTR_PC_IN,
    input wire logic REPEAT_LOAD_IN,
    input wire logic [7:0] REPEAT_VALUE_IN,
    input wire logic [31:0] DATA_OPERAND_IN,
    input wire logic [31:0] MULTIPLICAND_IN,
    input wire logic [3:0] PRODUCT_SHIFT_MODE_IN,
    input wire logic LOC_WRITES_AUX_POINTER_SEVEN_IN,
    input wire logic [31:0] LOC_AUX_POINTER_SEVEN_VALUE_IN,
    input wire logic AUX_POINTER_SEVEN_LOAD_IN,
    input wire logic [31:0] AUX_POINTER_SEVEN_VALUE_IN,
    input wire logic [31:0] PROG_DATA_IN,
    input wire logic PIPE_FLUSHED_IN,
    input wire logic MEM_IDLE_IN,
    input wire logic IBUF_FULL_IN,
    input wire logic [15:0] IRQ_LINES_IN,
    input wire logic NMI_IN,
    input wire logic [15:0] IRQ_ENABLE_MASK_IN,
    input wire logic GLOBAL_IRQ_MASK_IN,
    output logic INSTR_READY_OUT,
    output logic [15:0] DATA_BUS_OUT,
    output logic DATA_BUS_EN_OUT,
    output logic [7:0] REPEAT_COUNT_OUT,
    output logic [21:0] PROG_ADDR_OUT,
    output logic PROG_RD_OUT,
    output logic [31:0] AUX_POINTER_SEVEN_OUT,
    output logic [31:0] ACC_OUT,
    output logic [31:0] PRODUCT_OUT,
    output cim_pkg::cim_flags_t FLAGS_OUT,
    output logic [OVC_W-1:0] UNSIGNED_CARRY_COUNTER_OUT,
    output logic IDLE_STATUS_FLAG_OUT,
    output logic CORE_CLK_EN_OUT,
    output logic CORE_CLOCK_OUT_EN_OUT,
    output logic IDLE_OUT,
    output logic [21:0] PC_OUT,
    output logic ISR_TAKE_OUT
);
    import cim_pkg::*;

    // A counter wider than the accumulator word has no meaning here
    if (OVC_W < 1 || OVC_W > 32) begin : g_bad_ovc_w
        $error("OVC_W out of range");
    end

    // ******************************
    // Decode
    // ******************************
    logic accept;
    logic dec_interrupt_ack_instr;
    logic dec_idle;
    logic dec_macl;
    logic dec_mpyal;
    logic macl_inc;
    assign accept = INSTR_VALID_IN && INSTR_READY_OUT;
    assign dec_interrupt_ack_instr = INSTR_WORD_IN[31:16] == OP_INTERRUPT_ACK_INSTR;
    assign dec_idle = INSTR_WORD_IN[31:16] == OP_IDLE;
    // Two encodings of the program MAC
    assign macl_inc = INSTR_WORD_IN[15:8] == MACL_POSTINC;
    assign dec_macl = INSTR_WORD_IN[31:16] == OP_MACL &&
        (INSTR_WORD_IN[15:8] == MACL_NOINC || macl_inc);
    assign dec_mpyal = INSTR_WORD_IN[31:16] == OP_MPYAL && INSTR_WORD_IN[15:8] == MPYAL_SUB;

    // ******************************
    // Arithmetic helpers
    // ******************************
    function automatic cim_accres_t acc_add(input logic [31:0] a, input logic [31:0] p);
        logic [32:0] sum;
        cim_accres_t r;
        sum = {1'b0, a} + {1'b0, p};
        r.acc = sum[31:0];
        r.c = sum[32];
        r.v = (a[31] == p[31]) && (sum[31] != a[31]);
        return r;
    endfunction

    function automatic logic [31:0] pm_select(input logic [3:0] pm, input logic [31:0] x,
                                              input logic [31:0] y);
        logic signed [63:0] prod;
        logic [TEMP_W-1:0] t;
        logic [31:0] r;
        prod = $signed(x) * $signed(y);
        t = prod[TEMP_W-1:0];
        // Only the low 38 bits ever reach the product register
        case (pm)
            PM_L4: r = {t[27:0], 4'h0};
            PM_L1: r = {t[30:0], 1'b0};
            PM_ZERO: r = t[31:0];
            PM_R1: r = t[32:1];
            PM_R2: r = t[33:2];
            PM_R3: r = t[34:3];
            PM_R4: r = t[35:4];
            PM_R5: r = t[36:5];
            PM_R6: r = t[37:6];
            default: r = t[31:0];
        endcase
        return r;
    endfunction

    // ******************************
    // Interrupt input synchronisers
    // ******************************
    logic [SYNC_N-1:0] sync_raw;
    logic [SYNC_N-1:0] sync_1_r;
    logic [SYNC_N-1:0] sync_2_r;
    logic [SYNC_N-1:0] sync_3_r;
    logic [SYNC_N-1:0] sync_f_r;
    assign sync_raw = {NMI_IN, IRQ_LINES_IN};
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            // A level is taken only once the last two stages agree
            always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    sync_1_r[gi] <= 1'b0;
                    sync_2_r[gi] <= 1'b0;
                    sync_3_r[gi] <= 1'b0;
                    sync_f_r[gi] <= 1'b0;
                end else begin
                    sync_1_r[gi] <= sync_raw[gi];
                    sync_2_r[gi] <= sync_1_r[gi];
                    sync_3_r[gi] <= sync_2_r[gi];
                    if (sync_2_r[gi] == sync_3_r[gi]) begin
                        sync_f_r[gi] <= sync_3_r[gi];
                    end
                end
            end
        end
    endgenerate

    logic nmi_f;
    logic irq_hit;
    logic wake;
    assign nmi_f = sync_f_r[IRQ_N];
    // Global mask deliberately not part of the wake term
    assign irq_hit = |(sync_f_r[IRQ_N-1:0] & IRQ_ENABLE_MASK_IN);
    assign wake = irq_hit || nmi_f;

    // ******************************
    // Idle sequencer
    // ******************************
    cim_idle_t idle_r;
    logic sleep_wake;
    assign sleep_wake = idle_r == IDL_SLEEP && wake;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            idle_r <= IDL_RUN;
            IDLE_STATUS_FLAG_OUT <= 1'b0;
            CORE_CLK_EN_OUT <= 1'b1;
            IDLE_OUT <= 1'b0;
            ISR_TAKE_OUT <= 1'b0;
        end else begin
            ISR_TAKE_OUT <= 1'b0;
            case (idle_r)
                IDL_RUN: begin
                    if (accept && dec_idle) begin
                        idle_r <= IDL_FLUSH;
                    end
                end
                IDL_FLUSH: begin
                    if (PIPE_FLUSHED_IN) begin
                        idle_r <= IDL_DRAIN;
                    end
                end
                IDL_DRAIN: begin
                    if (MEM_IDLE_IN) begin
                        idle_r <= IDL_FILL;
                        IDLE_STATUS_FLAG_OUT <= 1'b1;
                    end
                end
                IDL_FILL: begin
                    if (IBUF_FULL_IN) begin
                        idle_r <= IDL_GATED;
                        CORE_CLK_EN_OUT <= 1'b0;
                    end
                end
                IDL_GATED: begin
                    idle_r <= IDL_SLEEP;
                    IDLE_OUT <= 1'b1;
                end
                IDL_SLEEP: begin
                    if (wake) begin
                        idle_r <= IDL_RUN;
                        IDLE_STATUS_FLAG_OUT <= 1'b0;
                        CORE_CLK_EN_OUT <= 1'b1;
                        IDLE_OUT <= 1'b0;
                        // Masked wake skips the routine and resumes after idle
                        ISR_TAKE_OUT <= nmi_f || !GLOBAL_IRQ_MASK_IN;
                    end
                end
                default: idle_r <= IDL_RUN;
            endcase
        end
    end

    // Clocks outside the core are off in reset, then never stop
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CORE_CLOCK_OUT_EN_OUT <= 1'b0;
        end else begin
            CORE_CLOCK_OUT_EN_OUT <= 1'b1;
        end
    end

    // PC stays on the idle opcode until wake
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PC_OUT <= PC_RST;
        end else if (accept) begin
            PC_OUT <= INSTR_PC_IN;
        end else if (sleep_wake) begin
            PC_OUT <= PC_OUT + 22'h000001;
        end
    end

    // ******************************
    // Interrupt acknowledge
    // ******************************
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DATA_BUS_OUT <= 16'h0000;
            DATA_BUS_EN_OUT <= 1'b0;
        end else begin
            DATA_BUS_EN_OUT <= accept && dec_interrupt_ack_instr;
            if (accept && dec_interrupt_ack_instr) begin
                DATA_BUS_OUT <= INSTR_WORD_IN[IMM_W-1:0];
            end
        end
    end

    // ******************************
    // Multiply-accumulate datapath
    // ******************************
    cim_mac_t mac_r;
    logic postinc_r;
    logic mac_last;
    logic [31:0] aux_pointer_seven_nxt;
    logic [PADDR_W-1:0] prog_step;
    cim_accres_t add_res;
    assign prog_step = {{(PADDR_W-1){1'b0}}, postinc_r};
    assign mac_last = mac_r == MAC_EXEC && REPEAT_COUNT_OUT == RPT_RST;
    assign add_res = acc_add(ACC_OUT, PRODUCT_OUT);

    always_comb begin
        aux_pointer_seven_nxt = AUX_POINTER_SEVEN_OUT;
        if (LOC_WRITES_AUX_POINTER_SEVEN_IN) begin
            aux_pointer_seven_nxt = LOC_AUX_POINTER_SEVEN_VALUE_IN;
        end else if (postinc_r) begin
            aux_pointer_seven_nxt = AUX_POINTER_SEVEN_OUT + 32'h00000001;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mac_r <= MAC_OFF;
            postinc_r <= 1'b0;
        end else begin
            case (mac_r)
                MAC_OFF: begin
                    if (accept && dec_macl) begin
                        mac_r <= MAC_FETCH;
                        postinc_r <= macl_inc;
                    end
                end
                MAC_FETCH: mac_r <= MAC_EXEC;
                MAC_EXEC: begin
                    if (mac_last) begin
                        mac_r <= MAC_OFF;
                    end
                end
                default: mac_r <= MAC_OFF;
            endcase
        end
    end

    // Repeat count: loaded by prefix, cleared by non-repeatable ones
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            REPEAT_COUNT_OUT <= RPT_RST;
        end else if (mac_r == MAC_EXEC && !mac_last) begin
            REPEAT_COUNT_OUT <= REPEAT_COUNT_OUT - 8'h01;
        end else if (accept && (dec_interrupt_ack_instr || dec_idle || dec_mpyal)) begin
            REPEAT_COUNT_OUT <= RPT_RST;
        end else if (REPEAT_LOAD_IN && INSTR_READY_OUT) begin
            REPEAT_COUNT_OUT <= REPEAT_VALUE_IN;
        end
    end

    // Program reads confined to 22-bit space; pointer seven itself is kept as 32 bits
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            AUX_POINTER_SEVEN_OUT <= WORD_RST;
            PROG_ADDR_OUT <= PC_RST;
            PROG_RD_OUT <= 1'b0;
        end else if (mac_r == MAC_OFF) begin
            if (AUX_POINTER_SEVEN_LOAD_IN) begin
                AUX_POINTER_SEVEN_OUT <= AUX_POINTER_SEVEN_VALUE_IN;
            end
            PROG_RD_OUT <= accept && dec_macl;
            PROG_ADDR_OUT <= AUX_POINTER_SEVEN_OUT[PADDR_W-1:0];
        end else if (mac_r == MAC_FETCH) begin
            // Reads run two cycles ahead of use, so the second address leaves here
            PROG_ADDR_OUT <= AUX_POINTER_SEVEN_OUT[PADDR_W-1:0] + prog_step;
            PROG_RD_OUT <= REPEAT_COUNT_OUT != RPT_RST;
        end else if (mac_r == MAC_EXEC) begin
            // Limitation: an operand-field rewrite steers reads only two cycles later
            AUX_POINTER_SEVEN_OUT <= aux_pointer_seven_nxt;
            PROG_ADDR_OUT <= aux_pointer_seven_nxt[PADDR_W-1:0] + prog_step;
            PROG_RD_OUT <= REPEAT_COUNT_OUT > 8'h01;
        end
    end

    // Accumulate, product and flags shared by both multiply forms
    logic do_acc;
    logic [31:0] mul_a;
    assign do_acc = mac_r == MAC_EXEC || (accept && dec_mpyal);
    assign mul_a = (mac_r == MAC_EXEC) ? PROG_DATA_IN : MULTIPLICAND_IN;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ACC_OUT <= WORD_RST;
            PRODUCT_OUT <= WORD_RST;
            FLAGS_OUT <= '0;
            UNSIGNED_CARRY_COUNTER_OUT <= '0;
        end else if (do_acc) begin
            ACC_OUT <= add_res.acc;
            PRODUCT_OUT <= pm_select(PRODUCT_SHIFT_MODE_IN, mul_a, DATA_OPERAND_IN);
            FLAGS_OUT.z <= add_res.acc == WORD_RST;
            FLAGS_OUT.n <= add_res.acc[31];
            FLAGS_OUT.c <= add_res.c;
            FLAGS_OUT.v <= FLAGS_OUT.v || add_res.v;
            UNSIGNED_CARRY_COUNTER_OUT <= UNSIGNED_CARRY_COUNTER_OUT +
                OVC_W'(add_res.c);
        end
    end

    // Ready only when both sequencers rest and no start is being taken
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            INSTR_READY_OUT <= 1'b0;
        end else begin
            INSTR_READY_OUT <= (idle_r == IDL_RUN || sleep_wake) &&
                !(accept && (dec_idle || dec_macl)) &&
                (mac_r == MAC_OFF || mac_last) && !(mac_r == MAC_FETCH);
        end
    end

    // ******************************
    // Assertions
    // ******************************
    sequence s_interrupt_ack_instr_take;
        accept && dec_interrupt_ack_instr;
    endsequence
    sequence s_bus_pulse;
        DATA_BUS_EN_OUT ##1 DATA_BUS_EN_OUT == $past(accept && dec_interrupt_ack_instr);
    endsequence
    sequence s_mac_one;
        accept && dec_macl && REPEAT_COUNT_OUT == RPT_RST;
    endsequence

    a_interrupt_ack_instr_drive: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_interrupt_ack_instr_take |=> s_bus_pulse and (DATA_BUS_OUT == $past(INSTR_WORD_IN[15:0])))
        else $error("acknowledge immediate not driven for one cycle");
    a_repeat_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        accept && (dec_interrupt_ack_instr || dec_idle || dec_mpyal) |=> REPEAT_COUNT_OUT == RPT_RST)
        else $error("repeat count not cleared");
    a_idle_order: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(IDLE_STATUS_FLAG_OUT) |-> $past(idle_r == IDL_DRAIN && MEM_IDLE_IN))
        else $error("idle status set out of order");
    a_gate_after_full: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $fell(CORE_CLK_EN_OUT) |-> $past(IBUF_FULL_IN) && IDLE_STATUS_FLAG_OUT)
        else $error("core clock gated before buffer full");
    a_idle_out_late: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $rose(IDLE_OUT) |-> !CORE_CLK_EN_OUT && $past(!CORE_CLK_EN_OUT))
        else $error("idle output raised before clock stopped");
    a_pc_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        idle_r == IDL_SLEEP && !wake |=> $stable(PC_OUT))
        else $error("pc moved while idle");
    a_wake_exit: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        sleep_wake |=> !IDLE_STATUS_FLAG_OUT && !IDLE_OUT && CORE_CLK_EN_OUT &&
        PC_OUT == $past(PC_OUT) + 22'h000001)
        else $error("wake did not exit idle correctly");
    a_wake_isr: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        sleep_wake |=> ISR_TAKE_OUT == ($past(nmi_f) || $past(!GLOBAL_IRQ_MASK_IN)))
        else $error("service routine choice wrong");
    a_mac_length: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_mac_one |=> !INSTR_READY_OUT [*2] ##1 INSTR_READY_OUT)
        else $error("single mac not two cycles");
    a_postinc: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mac_r == MAC_EXEC && postinc_r && !LOC_WRITES_AUX_POINTER_SEVEN_IN |=>
        AUX_POINTER_SEVEN_OUT == $past(AUX_POINTER_SEVEN_OUT) + 32'h00000001)
        else $error("pointer not post incremented");
    a_loc_priority: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        mac_r == MAC_EXEC && LOC_WRITES_AUX_POINTER_SEVEN_IN |=>
        AUX_POINTER_SEVEN_OUT == $past(LOC_AUX_POINTER_SEVEN_VALUE_IN))
        else $error("operand field lost pointer priority");
    a_v_sticky: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        FLAGS_OUT.v |=> FLAGS_OUT.v)
        else $error("overflow flag not sticky");
    a_zn_flags: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $past(do_acc) |-> FLAGS_OUT.z == (ACC_OUT == WORD_RST) && FLAGS_OUT.n == ACC_OUT[31])
        else $error("zero or negative flag wrong");
endmodule
`default_nettype wire

// ===== dv/cim_prog_mem.sv
// Purpose: Program memory at the far side of the executor's program read port.
// Assumes: Read data is due the cycle after a read strobe.
// Notes: Between reads the data lines toggle so a stale word never passes for a fresh one.
`timescale 1ns/10ps
`default_nettype none
module cim_prog_mem (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [21:0] addr_in,
    output logic [31:0] data_out
);
    initial data_out = 32'h0;
    // Negative words so the signed multiply is exercised
    always @(posedge clk_in) begin
        data_out <= rd_in ? {10'h3FF, addr_in} : ~data_out;
    end
endmodule
`default_nettype wire

// ===== dv/test_cim_exec.sv
// Purpose: Self-checking bench for the idle, acknowledge and MAC executor.
// Assumes: Program memory model answers one cycle after a read strobe.
// Notes: Operand-field override of pointer seven is tried on a single MAC only.
`timescale 1ns/10ps
`default_nettype none
module test_cim_exec;
    import cim_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, rld = 1'b0, xld = 1'b0, nmi = 1'b0, gm = 1'b0;
    logic fl = 1'b0, mi = 1'b0, ib = 1'b0, rdy, ben, prd, stat, cen, coen, idl, isr, e_c = 1'b0;
    logic [31:0] word = 32'h0, dop = 32'h0, xt = 32'hFFFFFFF3, xv = 32'h0, pd, ptr, acc, prod;
    logic [21:0] pc = 22'h000100, pa, pco;
    logic [7:0] rv = 8'h00, rc;
    logic [3:0] pm = 4'h0;
    logic [15:0] irq = 16'h0, ien = 16'h0, bus, cnt, e_cnt = 16'h0;
    logic [31:0] e_acc = 32'h0, e_p = 32'h0, lv = 32'h0001_2345;
    logic e_v = 1'b0, lw = 1'b0;
    cim_flags_t flg;
    int num_errors = 0, num_checks = 0, cyc = 0;
    cim_exec i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld), .INSTR_WORD_IN(word),
        .INSTR_PC_IN(pc), .REPEAT_LOAD_IN(rld), .REPEAT_VALUE_IN(rv), .DATA_OPERAND_IN(dop),
        .MULTIPLICAND_IN(xt), .PRODUCT_SHIFT_MODE_IN(pm), .LOC_WRITES_AUX_POINTER_SEVEN_IN(lw),
        .LOC_AUX_POINTER_SEVEN_VALUE_IN(lv), .AUX_POINTER_SEVEN_LOAD_IN(xld), .AUX_POINTER_SEVEN_VALUE_IN(xv), .PROG_DATA_IN(pd),
        .PIPE_FLUSHED_IN(fl), .MEM_IDLE_IN(mi), .IBUF_FULL_IN(ib), .IRQ_LINES_IN(irq),
        .NMI_IN(nmi), .IRQ_ENABLE_MASK_IN(ien), .GLOBAL_IRQ_MASK_IN(gm), .INSTR_READY_OUT(rdy),
        .DATA_BUS_OUT(bus), .DATA_BUS_EN_OUT(ben), .REPEAT_COUNT_OUT(rc), .PROG_ADDR_OUT(pa),
        .PROG_RD_OUT(prd), .AUX_POINTER_SEVEN_OUT(ptr), .ACC_OUT(acc), .PRODUCT_OUT(prod),
        .FLAGS_OUT(flg), .UNSIGNED_CARRY_COUNTER_OUT(cnt), .IDLE_STATUS_FLAG_OUT(stat),
        .CORE_CLK_EN_OUT(cen), .CORE_CLOCK_OUT_EN_OUT(coen), .IDLE_OUT(idl), .PC_OUT(pco),
        .ISR_TAKE_OUT(isr));
    cim_prog_mem i_mem (.clk_in(clk), .rd_in(prd), .addr_in(pa), .data_out(pd));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(input logic [31:0] w);
        @(posedge clk);
        vld <= 1'b1;
        word <= w;
        pc <= pc + 22'h1;
        do @(posedge clk); while (rdy !== 1'b1);
        vld <= 1'b0;
    endtask
    // ****************
    // Reference model
    // ****************
    function automatic logic [31:0] sh(input logic [63:0] t, input logic [3:0] m);
        if (m == 4'h0) sh = {t[27:0], 4'h0};
        else if (m == 4'h1) sh = {t[30:0], 1'b0};
        else if (m >= 4'h3 && m <= 4'h8) sh = 32'(t >> (m - 4'h2));
        else sh = t[31:0];
    endfunction
    task automatic mstep(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, e_acc} + {1'b0, e_p};
        if (e_acc[31] == e_p[31] && s[31] != e_acc[31]) e_v = 1'b1;
        e_c = s[32];
        e_cnt = e_cnt + 16'(s[32]);
        e_acc = s[31:0];
        e_p = sh($signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b}), pm);
    endtask
    task automatic chk_acc();
        chk({acc, prod}, {e_acc, e_p});
        chk({flg, cnt}, {e_acc == 32'h0, e_acc[31], e_c, e_v, e_cnt});
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_ack();
        @(posedge clk);
        rld <= 1'b1;
        rv <= 8'h05;
        @(posedge clk);
        rld <= 1'b0;
        issue(32'h763F_A5C3);
        @(negedge clk);
        chk({ben, bus, rc}, {1'b1, 16'hA5C3, 8'h00});
        @(negedge clk);
        chk(ben, 1'b0);
        $display("ack test done");
    endtask
    task automatic t_mpy();
        for (int m = 0; m < 9; m++) begin
            @(posedge clk);
            pm <= 4'(m);
            dop <= 32'h8000_0041 + 32'(m << 12);
            issue(32'h564C_0000);
            mstep(xt, dop);
            @(negedge clk);
            chk_acc();
        end
        $display("multiply add test done");
    endtask
    task automatic t_mac(input logic [7:0] enc, input logic [7:0] n, input logic inc,
                         input logic lw_e);
        int low;
        logic [31:0] a;
        @(posedge clk);
        lw <= lw_e;
        xld <= 1'b1;
        xv <= 32'h003F_FFFD;
        rld <= 1'b1;
        rv <= n;
        @(posedge clk);
        xld <= 1'b0;
        rld <= 1'b0;
        issue({16'h564D, enc, 8'h00});
        low = 0;
        @(negedge clk);
        while (rdy !== 1'b1 && low < 40) begin
            low++;
            @(negedge clk);
        end
        chk(low, n + 2);
        a = xv;
        for (int i = 0; i <= n; i++) begin
            mstep(dop, {10'h3FF, a[21:0]});
            a = a + 32'(inc);
        end
        if (lw_e) begin
            a = lv;
        end
        chk_acc();
        chk({ptr, rc}, {a, 8'h00});
        $display("mac test done");
    endtask
    task automatic t_idle(input logic n, input logic g, input logic isr_e);
        logic [21:0] ipc;
        int k;
        @(posedge clk);
        fl <= 1'b0;
        mi <= 1'b0;
        ib <= 1'b0;
        irq <= 16'h0;
        nmi <= 1'b0;
        ien <= 16'h0;
        gm <= g;
        issue(32'h7621_0000);
        ipc = pc;
        repeat (4) @(negedge clk);
        chk(stat, 1'b0);
        @(posedge clk) fl <= 1'b1;
        repeat (4) @(negedge clk);
        chk(stat, 1'b0);
        @(posedge clk) mi <= 1'b1;
        repeat (4) @(negedge clk);
        chk({stat, cen}, 2'b11);
        @(posedge clk) ib <= 1'b1;
        repeat (4) @(negedge clk);
        chk({cen, idl, coen, pco}, {3'b011, ipc});
        @(posedge clk);
        irq <= 16'h0008;
        nmi <= n;
        if (!n) begin
            repeat (10) @(negedge clk);
            chk(idl, 1'b1);
            @(posedge clk) ien <= 16'h0008;
        end
        k = 0;
        @(negedge clk);
        while (idl === 1'b1 && k < 20) begin
            k++;
            @(negedge clk);
        end
        chk({isr, stat, cen, rdy, pco}, {isr_e, 3'b011, ipc + 22'h1});
        $display("idle test done");
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_ack();
        t_mpy();
        t_mac(8'h87, 8'h02, 1'b1, 1'b0);
        t_mac(8'h87, 8'h00, 1'b1, 1'b1);
        t_mac(8'hC7, 8'h00, 1'b0, 1'b0);
        t_idle(1'b0, 1'b1, 1'b0);
        t_idle(1'b0, 1'b0, 1'b1);
        t_idle(1'b1, 1'b1, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
